// ==== dect_defines.svh ====
// Purpose: Constants for the dual event counter/timer.
// Assumes: 100 MHz ref_clk.
// Notes: Timing counts derive from the clock period.
`ifndef DECT_DEFINES_SVH
`define DECT_DEFINES_SVH
`define DECT_CNT_W 32
`define DECT_SRC_W 5
`define DECT_ACT_W 3
`define DECT_CLK_MHZ 100
`define DECT_TICK_US 1
`define DECT_TICK_CYC (`DECT_TICK_US * `DECT_CLK_MHZ)
`define DECT_CNT_RST 32'h0000_0000
`endif

// ==== dect_pkg.sv ====
// Purpose: Types for the dual event counter/timer.
// Assumes: Constants come from dect_defines.svh.
// Notes: Source codes follow the selection order of the source list.
`include "dect_defines.svh"
package dect_pkg;
	typedef enum logic [4:0] {
		DECT_SRC_OFF = 5'h00, DECT_SRC_MHZ = 5'h01,
		DECT_SRC_LINE0 = 5'h02, DECT_SRC_LINE1 = 5'h03, DECT_SRC_LINE2 = 5'h04, DECT_SRC_LINE3 = 5'h05,
		DECT_SRC_UOUT0 = 5'h06, DECT_SRC_UOUT1 = 5'h07, DECT_SRC_UOUT2 = 5'h08, DECT_SRC_UOUT3 = 5'h09,
		DECT_SRC_C0START = 5'h0a, DECT_SRC_C1START = 5'h0b, DECT_SRC_C0END = 5'h0c, DECT_SRC_C1END = 5'h0d,
		DECT_SRC_LB0 = 5'h0e, DECT_SRC_LB1 = 5'h0f,
		DECT_SRC_EXPSTART = 5'h10, DECT_SRC_EXPEND = 5'h11, DECT_SRC_FTWAIT = 5'h12
	} dect_src_t;
	typedef enum logic [2:0] {
		DECT_ACT_LOW = 3'h0, DECT_ACT_HIGH = 3'h1, DECT_ACT_FALL = 3'h2,
		DECT_ACT_RISE = 3'h3, DECT_ACT_ANY = 3'h4
	} dect_act_t;
	typedef enum logic [1:0] {
		DECT_ST_IDLE = 2'h0, DECT_ST_WAIT = 2'h1, DECT_ST_ACTIVE = 2'h2, DECT_ST_DONE = 2'h3
	} dect_status_t;
	typedef struct packed {
		dect_src_t inc_src;
		dect_act_t inc_act;
		dect_src_t trig_src;
		dect_act_t trig_act;
		dect_src_t clr_src;
		dect_act_t clr_act;
		logic [`DECT_CNT_W-1:0] start_thr;
		logic [`DECT_CNT_W-1:0] end_thr;
	} dect_cfg_t;
	typedef struct packed {
		dect_status_t st;
		logic [`DECT_CNT_W-1:0] cnt;
		logic [`DECT_CNT_W-1:0] cap;
		logic [18:0] src_prev;
		logic start_p;
		logic end_p;
	} dect_unit_t;
	typedef struct packed {
		dect_unit_t [1:0] u;
		dect_cfg_t [1:0] cfg;
		logic [6:0] tick_div;
		logic tick_lvl;
		logic [`DECT_CNT_W-1:0] rd_present;
		logic [`DECT_CNT_W-1:0] rd_captured;
		dect_status_t rd_state;
	} dect_state_t;
endpackage

// ==== dect_counter_timer.sv ====
// Purpose: Two selectable event counter/timers with start and end events.
// Assumes: All inputs synchronous to ref_clk; configuration written through plain ports.
// Notes: Configuration write targets the unit chosen by tally_unit_select.
`timescale 1ns/100ps
`include "dect_defines.svh"
module dect_counter_timer
	import dect_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic srst,
	// Camera signal sources.
	input wire logic [3:0] line_in,
	input wire logic [3:0] user_out,
	input wire logic [1:0] logic_block_out,
	input wire logic exposure_start,
	input wire logic exposure_end,
	input wire logic frame_trigger_wait,
	// Configuration, applied to the selected unit.
	input wire logic tally_unit_select,
	input wire logic cfg_wr,
	input wire dect_cfg_t cfg_wdata,
	// Readback of the selected unit.
	output logic [`DECT_CNT_W-1:0] tally_present,
	output logic [`DECT_CNT_W-1:0] tally_captured_at_clear,
	output dect_status_t tally_state,
	// Start and end event pulses.
	output logic [1:0] start_event,
	output logic [1:0] end_event
);
	dect_state_t s_q;
	dect_state_t s_d;
	logic [18:0] src_vec;

	logic [1:0] inc_hit;
	logic [1:0] trig_hit;
	logic [1:0] clr_hit;

	for (genvar g = 0; g < 2; g++) begin : g_unit
		dect_qualify #(
			.SRC_N(19)
		) u_inc_q (
			.sel(s_q.cfg[g].inc_src),
			.act(s_q.cfg[g].inc_act),
			.now(src_vec),
			.prev(s_q.u[g].src_prev),
			.hit(inc_hit[g])
		);
		dect_qualify #(
			.SRC_N(19)
		) u_trig_q (
			.sel(s_q.cfg[g].trig_src),
			.act(s_q.cfg[g].trig_act),
			.now(src_vec),
			.prev(s_q.u[g].src_prev),
			.hit(trig_hit[g])
		);
		dect_qualify #(
			.SRC_N(19)
		) u_clr_q (
			.sel(s_q.cfg[g].clr_src),
			.act(s_q.cfg[g].clr_act),
			.now(src_vec),
			.prev(s_q.u[g].src_prev),
			.hit(clr_hit[g])
		);
	end

	always_comb begin
		// Bit index equals the source code; bit 0 (off) never fires.
		src_vec = {frame_trigger_wait, exposure_end, exposure_start, logic_block_out,
			s_q.u[1].end_p, s_q.u[0].end_p, s_q.u[1].start_p, s_q.u[0].start_p,
			user_out, line_in, s_q.tick_lvl, 1'b0};
	end

	always_comb begin
		logic inc;
		logic trig;
		logic clr;
		logic [`DECT_CNT_W-1:0] nxt;
		inc = 1'b0;
		trig = 1'b0;
		clr = 1'b0;
		nxt = '0;
		s_d = s_q;
		s_d.tick_lvl = 1'b0;
		if (s_q.tick_div == 7'(`DECT_TICK_CYC - 1)) begin
			s_d.tick_div = '0;
			s_d.tick_lvl = 1'b1;
		end else begin
			s_d.tick_div = s_q.tick_div + 7'h01;
		end
		if (cfg_wr) begin
			s_d.cfg[tally_unit_select] = cfg_wdata;
			if (cfg_wdata.trig_src != DECT_SRC_OFF && cfg_wdata.trig_src != s_q.cfg[tally_unit_select].trig_src) begin
				s_d.cfg[tally_unit_select].clr_src = DECT_SRC_OFF;
			end else if (cfg_wdata.clr_src != DECT_SRC_OFF) begin
				s_d.cfg[tally_unit_select].trig_src = DECT_SRC_OFF;
			end
		end
		for (int i = 0; i < 2; i++) begin
			inc = inc_hit[i];
			trig = trig_hit[i];
			clr = clr_hit[i];
			s_d.u[i].src_prev = src_vec;
			s_d.u[i].start_p = 1'b0;
			s_d.u[i].end_p = 1'b0;
			nxt = s_q.u[i].cnt + `DECT_CNT_W'(1);
			if (clr && s_q.u[i].st != DECT_ST_IDLE) begin
				s_d.u[i].cap = s_q.u[i].cnt;
				s_d.u[i].cnt = `DECT_CNT_RST;
				s_d.u[i].st = (s_q.cfg[i].inc_src == DECT_SRC_OFF) ? DECT_ST_IDLE : DECT_ST_ACTIVE;
			end else begin
				unique case (s_q.u[i].st)
					DECT_ST_IDLE: begin
						if (s_q.cfg[i].inc_src != DECT_SRC_OFF) begin
							s_d.u[i].st = (s_q.cfg[i].trig_src != DECT_SRC_OFF) ? DECT_ST_WAIT : DECT_ST_ACTIVE;
						end
					end
					DECT_ST_WAIT: begin
						if (s_q.cfg[i].inc_src == DECT_SRC_OFF) begin
							s_d.u[i].st = DECT_ST_IDLE;
						end else if (trig || s_q.cfg[i].trig_src == DECT_SRC_OFF) begin
							s_d.u[i].st = DECT_ST_ACTIVE;
							s_d.u[i].cnt = `DECT_CNT_RST;
						end
					end
					DECT_ST_ACTIVE: begin
						if (s_q.cfg[i].inc_src == DECT_SRC_OFF) begin
							s_d.u[i].st = DECT_ST_IDLE;
						end else if (inc) begin
							s_d.u[i].cnt = nxt;
							if (nxt == s_q.cfg[i].start_thr) begin
								s_d.u[i].start_p = 1'b1;
							end
							if (nxt == s_q.cfg[i].end_thr) begin
								s_d.u[i].end_p = 1'b1;
								s_d.u[i].st = DECT_ST_DONE;
							end
						end
					end
					DECT_ST_DONE: begin
						if (s_q.cfg[i].inc_src == DECT_SRC_OFF) begin
							s_d.u[i].st = DECT_ST_IDLE;
						end else if (s_q.cfg[i].trig_src != DECT_SRC_OFF && trig) begin
							s_d.u[i].st = DECT_ST_ACTIVE;
							s_d.u[i].cnt = `DECT_CNT_RST;
						end
					end
				endcase
			end
		end
		s_d.rd_present = s_q.u[tally_unit_select].cnt;
		s_d.rd_captured = s_q.u[tally_unit_select].cap;
		s_d.rd_state = s_q.u[tally_unit_select].st;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tally_present = s_q.rd_present;
	assign tally_captured_at_clear = s_q.rd_captured;
	assign tally_state = s_q.rd_state;
	assign start_event = {s_q.u[1].start_p, s_q.u[0].start_p};
	assign end_event = {s_q.u[1].end_p, s_q.u[0].end_p};
endmodule

// Qualifies one selected source; activation applies to level sources only.
module dect_qualify
	import dect_pkg::*;
#(
	parameter int SRC_N = 19
)
(
	// Selection and activation.
	input wire dect_src_t sel,
	input wire dect_act_t act,
	// Source levels now and one cycle earlier.
	input wire logic [SRC_N-1:0] now,
	input wire logic [SRC_N-1:0] prev,
	// Qualified event.
	output logic hit
);
	logic c;
	logic p;

	always_comb begin
		c = now[sel];
		p = prev[sel];
		hit = 1'b0;
		if (sel == DECT_SRC_OFF) begin
			hit = 1'b0;
		end else if (sel == DECT_SRC_MHZ || sel >= DECT_SRC_C0START && sel <= DECT_SRC_C1END) begin
			// Pulse sources carry no activation; each pulse counts once.
			hit = c;
		end else begin
			unique case (act)
				DECT_ACT_LOW: hit = ~c;
				DECT_ACT_HIGH: hit = c;
				DECT_ACT_FALL: hit = p & ~c;
				DECT_ACT_RISE: hit = ~p & c;
				DECT_ACT_ANY: hit = p ^ c;
				default: hit = 1'b0;
			endcase
		end
	end
endmodule

// ==== dect_props.sv ====
// Purpose: Port assertions for the counter/timer.
// Assumes: Readback lags the unit state by one cycle.
// Notes: Event checks watch unit 1.
`timescale 1ns/100ps
module dect_props
	import dect_pkg::*;
(
	// Observed ports.
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic tally_unit_select,
	input wire logic cfg_wr,
	input wire logic [31:0] tally_present,
	input wire logic [31:0] tally_captured_at_clear,
	input wire dect_status_t tally_state,
	input wire logic [1:0] start_event,
	input wire logic [1:0] end_event
);
	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (srst);
	property p_rst; disable iff (1'b0) srst |=> tally_present == 0 && end_event == 2'h0
		&& tally_state == DECT_ST_IDLE; endproperty
	a_rst: assert property (p_rst) else $error("reset left outputs set");
	property p_sp; start_event[1] |=> !start_event[1]; endproperty
	a_sp: assert property (p_sp) else $error("start pulse too long");
	property p_ep; end_event[1] |=> !end_event[1]; endproperty
	a_ep: assert property (p_ep) else $error("end pulse too long");
	property p_step; (!cfg_wr && $stable(tally_unit_select)) [*3]
		|-> tally_present - $past(tally_present) <= 32'h1 || tally_present == 0; endproperty
	a_step: assert property (p_step) else $error("count jumped");
	property p_idle; (!cfg_wr && $stable(tally_unit_select)) [*3] ##0 tally_state == DECT_ST_IDLE
		|=> $stable(tally_present); endproperty
	a_idle: assert property (p_idle) else $error("idle count moved");
	property p_done; (!cfg_wr && $stable(tally_unit_select)) [*3] ##0 tally_state == DECT_ST_DONE
		##1 tally_state == DECT_ST_DONE |-> $stable(tally_present); endproperty
	a_done: assert property (p_done) else $error("done count moved");
	property p_end; tally_unit_select [*3] ##0 end_event[1] |-> ##[0:2] tally_state == DECT_ST_DONE; endproperty
	a_end: assert property (p_end) else $error("end without done");
	property p_cap; (!cfg_wr && $stable(tally_unit_select)) [*3] ##0 $changed(tally_captured_at_clear)
		|-> tally_present == 0 && tally_captured_at_clear == $past(tally_present); endproperty
	a_cap: assert property (p_cap) else $error("bad capture");
endmodule
bind dect_counter_timer dect_props u_dect_props (.ref_clk(ref_clk), .srst(srst),
	.tally_unit_select(tally_unit_select), .cfg_wr(cfg_wr), .tally_present(tally_present),
	.tally_captured_at_clear(tally_captured_at_clear), .tally_state(tally_state),
	.start_event(start_event), .end_event(end_event));

// ==== dect_src_model.sv ====
// Purpose: Camera signal levels feeding the counter/timer.
// Assumes: Toggle requests come on the falling edge.
// Notes: Bits are lines, user outputs, logic blocks, exposure start and end, trigger wait.
`timescale 1ns/100ps
module dect_src_model (
	// Toggle requests and levels.
	input wire logic ref_clk,
	input wire logic [12:0] tog,
	output logic [12:0] src
);
	logic [12:0] lvl = 13'h0000;
	always @(negedge ref_clk) lvl <= lvl ^ tog;
	assign src = lvl;
endmodule

// ==== tb.sv ====
// Purpose: Self-checking bench for the counter/timer.
// Assumes: Inputs change on the falling edge.
// Notes: Level rows see a six-cycle pulse.
`timescale 1ns/100ps
module tb;
	import dect_pkg::*;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic sel = 1'b0;
	logic cfg_wr = 1'b0;
	dect_cfg_t wd = '0;
	logic [12:0] tog = 13'h0000;
	logic [12:0] src;
	logic [31:0] pres, capt;
	dect_status_t st;
	logic [1:0] sev, eev;
	int mismatches = 0;
	int n_checks = 0;
	int ns = 0;
	int ne = 0;
	dect_act_t ra[6] = '{DECT_ACT_HIGH, DECT_ACT_RISE, DECT_ACT_FALL, DECT_ACT_ANY, DECT_ACT_LOW, DECT_ACT_RISE};
	logic rl[6] = '{0, 0, 0, 0, 1, 1};
	logic [31:0] re[6] = '{6, 1, 1, 2, 6, 1};
	always #5 ref_clk = ~ref_clk;
	// Pulses are counted mid-cycle, where they stand settled, for both units.
	always @(negedge ref_clk) begin
		ns <= ns + int'(sev[1]) + int'(sev[0]);
		ne <= ne + int'(eev[1]) + int'(eev[0]);
	end
	dect_src_model u_dect_src_model (.ref_clk(ref_clk), .tog(tog), .src(src));
	dect_counter_timer u_dect_counter_timer (.ref_clk(ref_clk), .srst(srst), .line_in(src[3:0]),
		.user_out(src[7:4]), .logic_block_out(src[9:8]), .exposure_start(src[10]), .exposure_end(src[11]),
		.frame_trigger_wait(src[12]), .tally_unit_select(sel), .cfg_wr(cfg_wr), .cfg_wdata(wd),
		.tally_present(pres), .tally_captured_at_clear(capt), .tally_state(st), .start_event(sev), .end_event(eev));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic tg(input int b, input int n);
		repeat (n) begin
			tog <= 13'h1 << b;
			@(negedge ref_clk);
			tog <= 13'h0;
			repeat (5) @(negedge ref_clk);
		end
	endtask
	task automatic rst;
		srst <= 1'b1;
		repeat (3) @(negedge ref_clk);
		srst <= 1'b0;
		repeat (4) @(negedge ref_clk);
	endtask
	task automatic cfg(input logic u, input dect_src_t i, input dect_act_t a, input dect_src_t t,
		input dect_src_t c, input logic [31:0] s, input logic [31:0] e);
		sel <= u;
		cfg_wr <= 1'b1;
		wd <= '{i, a, t, DECT_ACT_RISE, c, DECT_ACT_RISE, s, e};
		@(negedge ref_clk);
		cfg_wr <= 1'b0;
		repeat (3) @(negedge ref_clk);
	endtask
	task automatic print_verdict;
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#20000;
		mismatches++;
		print_verdict;
	end
	initial begin
		for (int i = 0; i < 6; i++) begin
			rst;
			if (src[0] !== rl[i]) tg(0, 1);
			cfg(1'b0, DECT_SRC_LINE0, ra[i], DECT_SRC_OFF, DECT_SRC_OFF, 32'h0, 32'h0);
			tg(0, 2);
			chk(pres, re[i]);
			$display("row %0d done", i);
		end
		rst;
		cfg(1'b0, DECT_SRC_C1END, DECT_ACT_RISE, DECT_SRC_OFF, DECT_SRC_OFF, 32'h1, 32'h1);
		cfg(1'b1, DECT_SRC_LINE1, DECT_ACT_RISE, DECT_SRC_OFF, DECT_SRC_OFF, 32'h2, 32'h3);
		tg(1, 8);
		chk(pres, 32'h3);
		chk(st, DECT_ST_DONE);
		chk(ns, 2);
		chk(ne, 2);
		sel <= 1'b0;
		repeat (3) @(negedge ref_clk);
		chk(pres, 32'h1);
		chk(st, DECT_ST_DONE);
		$display("thresholds done");
		rst;
		cfg(1'b0, DECT_SRC_LINE1, DECT_ACT_RISE, DECT_SRC_OFF, DECT_SRC_LINE2, 32'h0, 32'h0);
		tg(1, 6);
		tg(2, 2);
		chk(capt, 32'h3);
		chk(pres, 32'h0);
		// Stopping the unit first lets the new trigger source park it in the wait state.
		cfg(1'b0, DECT_SRC_OFF, DECT_ACT_RISE, DECT_SRC_OFF, DECT_SRC_OFF, 32'h0, 32'h0);
		cfg(1'b0, DECT_SRC_LINE1, DECT_ACT_RISE, DECT_SRC_LINE3, DECT_SRC_LINE2, 32'h0, 32'h0);
		tg(1, 2);
		tg(2, 2);
		chk(st, DECT_ST_WAIT);
		chk(pres, 32'h0);
		tg(3, 2);
		tg(1, 2);
		chk(st, DECT_ST_ACTIVE);
		chk(pres, 32'h1);
		chk(capt, 32'h3);
		$display("clear and trigger done");
		rst;
		// Activation low would count 99 of every 100 cycles; the tick must count once per 100 cycles.
		cfg(1'b1, DECT_SRC_MHZ, DECT_ACT_LOW, DECT_SRC_OFF, DECT_SRC_OFF, 32'h0, 32'h0);
		repeat (250) @(negedge ref_clk);
		chk(pres, 32'h2);
		$display("tick done");
		print_verdict;
	end
endmodule
